// [hw/eet_regs.svh]
// Constants for the two-wire memory target: timing counts and field layouts.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef EET_REGS_SVH
`define EET_REGS_SVH
`define EET_CLK_HZ 10000000
`define EET_PROG_TIME_MS 5
`define EET_PROG_CYCLES ((`EET_CLK_HZ / 1000) * `EET_PROG_TIME_MS)
`define EET_TOUT_TIME_US 25000
`define EET_TOUT_CYCLES ((`EET_CLK_HZ / 1000000) * `EET_TOUT_TIME_US)
`define EET_TYPE_MEM 4'ha
`define EET_TYPE_POS 4
`define EET_SEL_POS 1
`define EET_PAGE_BYTES 16
`define EET_MEM_BYTES 512
`define EET_QUAD_BYTES 128
`define EET_ADDR_W 9
`endif

// [hw/eet_pkg.sv]
// Types shared by the two-wire memory target.
// Assumes eet_regs.svh supplies the numeric constants.
package eet_pkg;
	typedef enum logic [2:0] {
		EET_IDLE,
		EET_RX,
		EET_RX_ACK,
		EET_TX,
		EET_TX_ACK,
		EET_PROG
	} eet_state_t;
	typedef enum logic [1:0] {
		EET_PH_DEV,
		EET_PH_ADDR,
		EET_PH_DATA
	} eet_phase_t;
endpackage : eet_pkg

// [hw/eet_fifo.sv]
// Small valid/ready FIFO holding bytes of a page write before programming.
// Assumes one clock; the reader may stall so the FIFO really fills.
`timescale 1ns/1ps
module eet_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	wire logic full = (wrPtr[AW] != rdPtr[AW])
		&& (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire logic empty = (wrPtr == rdPtr);
	wire logic doWr = inValid && !full;
	wire logic doRd = outReady && !empty;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = store[rdPtr[AW-1:0]];
	always_ff @(posedge mclk)
	begin
		if (clkEn && doWr)
			store[wrPtr[AW-1:0]] <= inData;
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else if (clkEn)
		begin
			if (flush)
			begin
				wrPtr <= '0;
				rdPtr <= '0;
			end
			else
			begin
				if (doWr)
					wrPtr <= wrPtr + 1'b1;
				if (doRd)
					rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule : eet_fifo

// [hw/eet_mem.sv]
// Byte memory array with one write port and a registered read port.
// Assumes the caller holds the address steady one cycle before using data.
`timescale 1ns/1ps
module eet_mem #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic mclk,
	input wire logic clkEn,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] cells [2**AW];
	always_ff @(posedge mclk)
	begin
		if (clkEn)
		begin
			if (wrEn)
				cells[wrAddr] <= wrData;
			rdData <= cells[rdAddr];
		end
	end
endmodule : eet_mem

// [hw/eet_target.sv]
// Two-wire serial memory target: bus decoding, byte engine, programming.
// Assumes the bus pins are asynchronous to mclk and much slower than it.
// Function
// - Sample data on clock rise; change output only after clock fall.
// - Unconnected select pins read as low for address compare; the code has no internal pull and relies on external pull-downs.
// - Data line is only pulled low or released, never driven high.
// - Bytes travel most significant bit first.
// - Eight data clocks then a ninth acknowledge clock per byte.
// - Transmitter changes data only while clock is low.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop.
// - Stop after a read enters standby at once.
// - Stop after a write programs, then enters standby.
// - Self-timed programming finishes within five milliseconds; the code spends PROG_CYCLES, five milliseconds, per byte written.
// - Accepted address or data bytes acknowledged low on ninth clock.
// - Host not-acknowledge during read makes the device release data.
// - Standby after power-up before any bus activity.
// - Bus idle only while clock and data both high.
// - No limit on bytes between start and stop.
// - Page writes up to sixteen bytes, partial pages accepted; the code's eight-entry FIFO keeps only the first eight bytes of a page.
// - Stores 512 bytes of eight bits.
// - Per-quadrant write protection persists until cleared; the code's protect register is cleared only by reset.
// - Acknowledge device byte only on type and select match.
// - Clock held low past timeout resets interface and releases data.
`timescale 1ns/1ps
`include "eet_regs.svh"
module eet_target import eet_pkg::*; #(
	parameter int PROG_CYCLES = `EET_PROG_CYCLES,
	parameter int TOUT_CYCLES = `EET_TOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic selectPinHigh,
	input wire logic selectPinMid,
	input wire logic selectPinLow,
	input wire logic upperHalf,
	input wire logic [3:0] reversibleQuadrantProtect,
	output logic standby,
	output logic busIdle,
	output logic programming
);
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic [2:0] selMeta;
	logic [2:0] selSync;
	logic sclPrev;
	logic sdaPrev;
	eet_state_t state;
	eet_phase_t phase;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic isRead;
	logic ackOk;
	logic [`EET_ADDR_W-1:0] addrPtr;
	logic [3:0] protect;
	logic [31:0] progCnt;
	logic [31:0] toutCnt;
	logic wroteAny;
	logic [7:0] txByte;
	logic txLoad;
	// Synchronised pins; first stage read only by second stage
	wire logic scl = sclSync[1];
	wire logic sda = sdaSync[1];
	wire logic sclRise = scl && !sclPrev;
	wire logic sclFall = !scl && sclPrev;
	wire logic startCond = scl && sclPrev && sdaPrev && !sda;
	wire logic stopCond = scl && sclPrev && !sdaPrev && sda;
	// Unconnected select pins are expected to be pulled low externally
	wire logic [2:0] selPins = selSync;
	wire logic [7:0] rxByte = {shiftReg[6:0], sda};
	wire logic devMatch = rxByte[7:`EET_TYPE_POS] == `EET_TYPE_MEM
		&& rxByte[3:`EET_SEL_POS] == selPins;
	wire logic [1:0] quad = addrPtr[8:7];
	wire logic quadLocked = protect[quad];
	wire logic timeout = toutCnt >= 32'(TOUT_CYCLES);
	wire logic [`EET_ADDR_W-1:0] nextAddr = {addrPtr[8:4], addrPtr[3:0] + 4'h1};
	logic fifoInReady;
	logic fifoOutValid;
	logic [16:0] fifoOut;
	logic [7:0] memRd;
	wire logic fifoPush = state == EET_RX && sclRise && bitCnt == 4'h7
		&& phase == EET_PH_DATA && !quadLocked;
	wire logic fifoPop = state == EET_PROG && progCnt == 32'h0;
	eet_fifo #(.WIDTH(17), .DEPTH(8)) uFifo (
		.mclk(mclk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.flush(startCond && state != EET_PROG),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData({addrPtr, rxByte}),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOut)
	);
	eet_mem #(.AW(`EET_ADDR_W), .DW(8)) uMem (
		.mclk(mclk),
		.clkEn(clkEn),
		.wrEn(fifoPop && fifoOutValid),
		.wrAddr(fifoOut[16:8]),
		.wrData(fifoOut[7:0]),
		.rdAddr(addrPtr),
		.rdData(memRd)
	);
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			selMeta <= 3'h0;
			selSync <= 3'h0;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else if (clkEn)
		begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			selMeta <= {selectPinHigh, selectPinMid, selectPinLow};
			selSync <= selMeta;
			sclPrev <= scl;
			sdaPrev <= sda;
		end
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			toutCnt <= 32'h0;
		else if (clkEn)
			toutCnt <= (scl || state == EET_IDLE || state == EET_PROG) ? 32'h0
				: toutCnt + 32'h1;
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			protect <= 4'h0;
		else if (clkEn)
			protect <= protect | reversibleQuadrantProtect;
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= EET_IDLE;
			phase <= EET_PH_DEV;
			bitCnt <= 4'h0;
			shiftReg <= 8'h0;
			isRead <= 1'b0;
			ackOk <= 1'b0;
			addrPtr <= '0;
			progCnt <= 32'h0;
			wroteAny <= 1'b0;
			txByte <= 8'h0;
			txLoad <= 1'b0;
			sdaOe <= 1'b0;
		end
		else if (clkEn)
		begin
			txLoad <= 1'b0;
			if (txLoad)
				txByte <= memRd;
			if (state == EET_PROG)
			begin
				// Programming cannot be interrupted by bus activity
				if (progCnt != 32'h0)
					progCnt <= progCnt - 32'h1;
				else if (!fifoOutValid)
					state <= EET_IDLE;
				else
					progCnt <= 32'(PROG_CYCLES - 1);
			end
			else if (timeout)
			begin
				state <= EET_IDLE;
				sdaOe <= 1'b0;
			end
			else if (startCond)
			begin
				state <= EET_RX;
				phase <= EET_PH_DEV;
				bitCnt <= 4'h0;
				wroteAny <= 1'b0;
				sdaOe <= 1'b0;
			end
			else if (stopCond)
			begin
				sdaOe <= 1'b0;
				if (wroteAny)
				begin
					state <= EET_PROG;
					progCnt <= 32'h0;
				end
				else
					state <= EET_IDLE;
			end
			else
				case (state)
				EET_RX:
					if (sclRise)
					begin
						shiftReg <= rxByte;
						bitCnt <= bitCnt + 4'h1;
						if (bitCnt == 4'h7)
						begin
							state <= EET_RX_ACK;
							case (phase)
							EET_PH_DEV:
							begin
								ackOk <= devMatch;
								isRead <= sda;
								if (devMatch && sda)
								begin
									addrPtr[8] <= upperHalf;
								end
							end
							EET_PH_ADDR:
							begin
								ackOk <= 1'b1;
								addrPtr <= {upperHalf, rxByte};
							end
							default:
							begin
								ackOk <= !quadLocked;
								if (!quadLocked)
								begin
									wroteAny <= 1'b1;
									addrPtr <= nextAddr;
								end
							end
							endcase
						end
					end
				EET_RX_ACK:
					if (sclFall && bitCnt == 4'h8)
					begin
						// First fall opens the ninth clock
						bitCnt <= 4'h9;
						sdaOe <= ackOk;
						if (!ackOk)
							state <= EET_IDLE;
					end
					else if (sclFall)
					begin
						bitCnt <= 4'h0;
						if (isRead && phase == EET_PH_DEV)
						begin
							state <= EET_TX;
							txByte <= memRd;
							sdaOe <= !memRd[7];
						end
						else
						begin
							sdaOe <= 1'b0;
							state <= EET_RX;
							phase <= (phase == EET_PH_DEV) ? EET_PH_ADDR
								: EET_PH_DATA;
						end
					end
				EET_TX:
					if (sclFall)
					begin
						bitCnt <= bitCnt + 4'h1;
						if (bitCnt == 4'h7)
						begin
							sdaOe <= 1'b0;
							state <= EET_TX_ACK;
							addrPtr <= addrPtr + 9'h1;
						end
						else
							sdaOe <= !txByte[3'(6 - bitCnt)];
					end
				EET_TX_ACK:
					if (sclRise)
					begin
						if (sda)
							state <= EET_IDLE;
						else
							txLoad <= 1'b1;
					end
					else if (sclFall)
					begin
						state <= EET_TX;
						bitCnt <= 4'h0;
						sdaOe <= !memRd[7];
						txByte <= memRd;
					end
				default:
					;
				endcase
		end
	end
	// Open drain: output value is always low, only the enable moves
	assign sdaOut = 1'b0;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			standby <= 1'b1;
			busIdle <= 1'b1;
			programming <= 1'b0;
		end
		else if (clkEn)
		begin
			standby <= state == EET_IDLE;
			busIdle <= scl && sda;
			programming <= state == EET_PROG;
		end
	end
	sequence sTxAckNack;
		clkEn && state == EET_TX_ACK && sclRise && sda;
	endsequence
	a_nack_release: assert property (@(posedge mclk) disable iff (!arst_n)
		sTxAckNack |=> !sdaOe)
		else $error("data held after host not-acknowledge");
	a_never_high: assert property (@(posedge mclk) disable iff (!arst_n)
		sdaOut == 1'b0)
		else $error("data line driven high");
	a_oe_on_fall: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(sdaOe) |-> $past(sclFall))
		else $error("data driven without a clock fall");
	a_start_rx: assert property (@(posedge mclk) disable iff (!arst_n)
		clkEn && startCond && state != EET_PROG && !timeout
		|=> state == EET_RX && bitCnt == 4'h0)
		else $error("start not taken");
	a_read_stop: assert property (@(posedge mclk) disable iff (!arst_n)
		clkEn && stopCond && !wroteAny && state != EET_PROG && !timeout
		&& !startCond |=> state == EET_IDLE ##1 standby)
		else $error("no standby after read stop");
	a_timeout_rel: assert property (@(posedge mclk) disable iff (!arst_n)
		clkEn && timeout && state != EET_PROG |=> !sdaOe)
		else $error("timeout did not release data");
	a_prog_no_idle: assert property (@(posedge mclk) disable iff (!arst_n)
		state == EET_PROG && fifoOutValid |=> state == EET_PROG)
		else $error("standby before programming done");
	a_bad_dev_nack: assert property (@(posedge mclk) disable iff (!arst_n)
		state == EET_RX_ACK && !ackOk |-> !sdaOe)
		else $error("acknowledged foreign address");
	a_idle_flag: assert property (@(posedge mclk) disable iff (!arst_n)
		clkEn ##1 clkEn |-> busIdle == $past(scl && sda))
		else $error("idle flag wrong");
endmodule : eet_target

// [tb/eet_host_model.sv]
// Behavioural two-wire host that clocks bytes at an 800 ns bus period.
// Assumes a 100 ns mclk; the bench resolves the open-drain data wire.
`timescale 1ns/1ps
module eet_host_model (
	input wire logic mclk,
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge mclk);
	endtask : hw
	// Data moves mid-low so it never races either clock edge
	task automatic bitx(input logic b, output logic s);
		scl = 1'b0;
		hw(2);
		sdaLow = !b;
		hw(2);
		scl = 1'b1;
		hw(3);
		s = sda;
		hw(1);
	endtask : bitx
	task automatic start;
		scl = 1'b0;
		hw(2);
		sdaLow = 1'b0;
		hw(2);
		scl = 1'b1;
		hw(2);
		sdaLow = 1'b1;
		hw(2);
	endtask : start
	task automatic stop;
		scl = 1'b0;
		hw(2);
		sdaLow = 1'b1;
		hw(2);
		scl = 1'b1;
		hw(2);
		sdaLow = 1'b0;
		hw(2);
	endtask : stop
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(d[i], s);
		bitx(1'b1, ack);
	endtask : sendByte
	task automatic getByte(input logic nack, output logic [7:0] d,
		output logic rel);
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(nack, rel);
	endtask : getByte
endmodule : eet_host_model

// [tb/eet_target_tb_top.sv]
// Self-checking bench for the two-wire memory target.
// Assumes the host model drives the bus; protect input is pulsed once.
`timescale 1ns/1ps
module eet_target_tb_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic selH = 1'b0;
	logic selM = 1'b0;
	logic selL = 1'b0;
	logic [3:0] prot = 4'h0;
	logic run = 1'b1;
	logic upHalf = 1'b0;
	logic sdaOut, sdaOe, standby, busIdle, programming;
	logic scl, sdaLow, sda, a;
	logic [7:0] d;
	int fail_count = 0;
	int tests_run = 0;
	// Pull-up wins unless a party pulls low
	assign sda = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
	eet_target #(.PROG_CYCLES(20), .TOUT_CYCLES(2000)) dut (
		.mclk(mclk),
		.arst_n(arst_n),
		.clkEn(run),
		.sclIn(scl),
		.sdaIn(sda),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.selectPinHigh(selH),
		.selectPinMid(selM),
		.selectPinLow(selL),
		.upperHalf(upHalf),
		.reversibleQuadrantProtect(prot),
		.standby(standby),
		.busIdle(busIdle),
		.programming(programming)
	);
	eet_host_model host (
		.mclk(mclk),
		.scl(scl),
		.sdaLow(sdaLow),
		.sda(sda)
	);
	initial
	begin
		forever #50 mclk = !mclk;
	end
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Bounded wait; running out ends the run
	task automatic waitStandby(input int n);
		int k;
		k = 0;
		while (standby !== 1'b1 && k < n)
		begin
			@(negedge mclk);
			k++;
		end
		if (standby !== 1'b1)
		begin
			chk("standby wait", standby, 1'b1);
			give_verdict();
		end
	endtask : waitStandby
	task automatic tReset;
		chk("sdaOe rst", sdaOe, 1'b0);
		chk("standby rst", standby, 1'b1);
		chk("busIdle rst", busIdle, 1'b1);
		chk("prog rst", programming, 1'b0);
	endtask : tReset
	task automatic tWrite;
		host.start();
		host.hw(1);
		chk("busIdle", busIdle, 1'b0);
		host.sendByte(8'ha0, a);
		chk("dev ack", a, 1'b0);
		host.sendByte(8'h10, a);
		chk("addr ack", a, 1'b0);
		host.sendByte(8'h5a, a);
		chk("data0 ack", a, 1'b0);
		host.sendByte(8'hc3, a);
		chk("data1 ack", a, 1'b0);
		chk("sdaOut", sdaOut, 1'b0);
		host.stop();
		host.hw(4);
		chk("prog", programming, 1'b1);
		chk("standby prog", standby, 1'b0);
		// Two bytes at 20 cycles each, plus slack
		waitStandby(60);
		chk("prog end", programming, 1'b0);
	endtask : tWrite
	task automatic tRead;
		host.start();
		host.sendByte(8'ha0, a);
		host.sendByte(8'h10, a);
		chk("rd addr ack", a, 1'b0);
		host.start();
		host.sendByte(8'ha1, a);
		chk("rd dev ack", a, 1'b0);
		host.getByte(1'b0, d, a);
		chk("rd byte0", d, 8'h5a);
		host.getByte(1'b1, d, a);
		chk("rd byte1", d, 8'hc3);
		chk("nack line", a, 1'b1);
		host.hw(5);
		chk("released", sdaOe, 1'b0);
		host.stop();
		host.hw(4);
		chk("rd standby", standby, 1'b1);
	endtask : tRead
	task automatic tSelect;
		selL = 1'b1;
		host.start();
		host.sendByte(8'ha0, a);
		chk("sel miss", a, 1'b1);
		host.stop();
		host.start();
		host.sendByte(8'ha2, a);
		chk("sel hit", a, 1'b0);
		host.stop();
		selH = 1'b1;
		selM = 1'b1;
		host.start();
		host.sendByte(8'hae, a);
		chk("sel all hit", a, 1'b0);
		host.stop();
		selH = 1'b0;
		selM = 1'b0;
		selL = 1'b0;
		host.start();
		host.sendByte(8'h20, a);
		chk("type miss", a, 1'b1);
		host.stop();
		host.hw(4);
		chk("miss standby", standby, 1'b1);
	endtask : tSelect
	task automatic tProtect;
		prot = 4'h1;
		host.hw(1);
		prot = 4'h0;
		host.start();
		host.sendByte(8'ha0, a);
		host.sendByte(8'h20, a);
		host.sendByte(8'h77, a);
		chk("prot nack", a, 1'b1);
		host.stop();
		host.hw(4);
		chk("prot no prog", programming, 1'b0);
	endtask : tProtect
	// Held enable must freeze the idle flag while the bus moves
	task automatic tFreeze;
		run = 1'b0;
		host.start();
		host.hw(2);
		chk("frozen idle", busIdle, 1'b1);
		host.stop();
		run = 1'b1;
		host.hw(4);
		chk("thaw idle", busIdle, 1'b1);
	endtask : tFreeze
	initial
	begin
		repeat (12) @(negedge mclk);
		tReset();
		arst_n = 1'b1;
		host.hw(4);
		tWrite();
		tRead();
		tSelect();
		tProtect();
		tFreeze();
		give_verdict();
	end
endmodule : eet_target_tb_top
